// File: rtl/epi_pkg.sv
// Constants for the external pin interrupt unit: register map, field
// positions, reset values, vector and synchroniser depth.
// Assumes a single 10 MHz bus clock and a synchronous active-high reset.
package epi_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          EPI_ADDR_W        = 4;
	localparam logic [3:0]  EPI_CTRL_OFFSET   = 4'h0;
	localparam logic [7:0]  EPI_CTRL_RESET    = 8'h00;

	// ----------------------------------------------------------------
	// Field positions of the control register
	// ----------------------------------------------------------------
	localparam int          EPI_MODE_BIT      = 0;
	localparam int          EPI_REQEN_BIT     = 1;
	localparam int          EPI_ACK_BIT       = 2;
	localparam int          EPI_FLAG_BIT      = 3;
	localparam int          EPI_PINEN_BIT     = 4;
	localparam int          EPI_POL_BIT       = 5;
	localparam int          EPI_PULLDIS_BIT   = 6;

	// ----------------------------------------------------------------
	// Vector and synchroniser
	// ----------------------------------------------------------------
	localparam logic [4:0]  EPI_VECTOR_NUM    = 5'h02;
	localparam logic [15:0] EPI_VECTOR_ADDR   = 16'hfffa;
	localparam int          EPI_SYNC_STAGES   = 2;

endpackage : epi_pkg

// File: rtl/epi_det_if.sv
// Interface between the control logic and the edge/level detector.
// Assumes both ends share mclk_i.
`timescale 1ns/10ps
interface epi_det_if;
	logic level_s;    // Synchronised pin level
	logic polarity;   // 1 = rising/high
	logic pin_enable; // Pin function on
	logic edge_evt;   // One-cycle edge pulse
	logic level_act;  // Pin at asserted level

	modport det (input level_s, input polarity, input pin_enable,
		output edge_evt, output level_act);
	modport ctl (output level_s, output polarity, output pin_enable,
		input edge_evt, input level_act);
endinterface : epi_det_if

// File: rtl/epi_sync.sv
// Pin synchroniser: a chain of flip-flops onto the bus clock.
// Assumes the pin may change at any time relative to mclk_i.
`timescale 1ns/10ps
module epi_sync
	import epi_pkg::*;
#(
	parameter int STAGES = EPI_SYNC_STAGES
) (
	input  wire logic mclk_i,
	input  wire logic reset_i,
	input  wire logic pin_i,
	output logic      level_o
);

	logic [STAGES-1:0] chain_reg;

	// Refuse a chain too short to settle metastability
	generate
		if (STAGES < 2) begin : g_bad
			$error("epi_sync needs at least two stages");
		end
	endgenerate

	// Shift chain; only the next stage reads each flop
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			chain_reg <= '0;
		end else begin
			chain_reg <= {chain_reg[STAGES-2:0], pin_i};
		end
	end

	assign level_o = chain_reg[STAGES-1];

	sync_delay_a: assert property (@(posedge mclk_i) disable iff (reset_i)
		$past(reset_i, STAGES) == 1'b0 |-> level_o == $past(pin_i, STAGES))
		else $error("synchroniser output does not follow pin");

endmodule : epi_sync

// File: rtl/epi_detect.sv
// Edge and level detector on the synchronised pin.
// Assumes level_s is already synchronous to mclk_i.
`timescale 1ns/10ps
module epi_detect (
	input  wire logic mclk_i,
	input  wire logic reset_i,
	epi_det_if.det    det
);

	logic prev_act_reg;
	logic prev_en_reg;
	logic prev_pol_reg;

	// Asserted level under the chosen polarity
	assign det.level_act = det.pin_enable &&
		(det.level_s == det.polarity);

	// Remember last cycle's view of the pin and settings
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			prev_act_reg <= 1'b0;
			prev_en_reg  <= 1'b0;
			prev_pol_reg <= 1'b0;
		end else begin
			prev_act_reg <= det.level_act;
			prev_en_reg  <= det.pin_enable;
			prev_pol_reg <= det.polarity;
		end
	end

	// Deasserted to asserted; settings must be stable so that turning
	// the pin on or flipping polarity is not taken as an edge
	assign det.edge_evt = det.level_act && !prev_act_reg && prev_en_reg &&
		(prev_pol_reg == det.polarity);

endmodule : epi_detect

// File: rtl/epi_top.sv
// External pin interrupt unit: control register, event flag, pull
// device control and CPU request with its fixed vector.
// Assumes a plain register port with read data one cycle after the
// read strobe, and a pin that may change at any time.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module epi_top
	import epi_pkg::*;
#(
	parameter int SYNC_STAGES = EPI_SYNC_STAGES
) (
	input  wire logic                  mclk_i,
	input  wire logic                  reset_i,
	input  wire logic [EPI_ADDR_W-1:0] reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic      [7:0]            reg_rdata_o,
	input  wire logic                  irq_pin_i,
	output logic                       pull_enable_o,
	output logic                       pull_down_o,
	output logic                       cpu_irq_o,
	output logic      [4:0]            vector_num_o,
	output logic      [15:0]           vector_addr_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic       mode_reg;
	logic       reqen_reg;
	logic       pinen_reg;
	logic       pol_reg;
	logic       pulldis_reg;
	logic       flag_reg;
	logic       flag_next;
	logic       ctrl_wr;
	logic       ctrl_rd;
	logic       ack_wr;
	logic       ack_honoured;
	logic       set_evt;
	logic [7:0] ctrl_view;
	logic [7:0] rdata_reg;
	logic       pull_en_reg;
	logic       pull_dn_reg;
	logic       irq_reg;
	logic       pin_level;

	epi_det_if det_bus ();

	// Refuse a synchroniser too short to settle the pin
	generate
		if (SYNC_STAGES < 2) begin : g_bad_sync
			$error("epi_top needs at least two synchroniser stages");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin synchroniser and detector
	// ----------------------------------------------------------------

	// Chain of SYNC_STAGES flops (two by default) ahead of all detection
	epi_sync #(
		.STAGES (SYNC_STAGES)
	) u_sync (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.pin_i   (irq_pin_i),
		.level_o (pin_level)
	);

	// Feed detector with the synchronised level and settings
	assign det_bus.level_s    = pin_level;
	assign det_bus.polarity   = pol_reg;
	assign det_bus.pin_enable = pinen_reg;

	epi_detect u_detect (
		.mclk_i  (mclk_i),
		.reset_i (reset_i),
		.det     (det_bus.det)
	);

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------

	// Strobes qualified by the single control address
	assign ctrl_wr = reg_wr_i && (reg_addr_i == EPI_CTRL_OFFSET);
	assign ctrl_rd = reg_rd_i && (reg_addr_i == EPI_CTRL_OFFSET);
	assign ack_wr  = ctrl_wr && reg_wdata_i[EPI_ACK_BIT];

	// Control bits written by software
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			mode_reg    <= EPI_CTRL_RESET[EPI_MODE_BIT];
			reqen_reg   <= EPI_CTRL_RESET[EPI_REQEN_BIT];
			pinen_reg   <= EPI_CTRL_RESET[EPI_PINEN_BIT];
			pol_reg     <= EPI_CTRL_RESET[EPI_POL_BIT];
			pulldis_reg <= EPI_CTRL_RESET[EPI_PULLDIS_BIT];
		end else if (ctrl_wr) begin
			mode_reg    <= reg_wdata_i[EPI_MODE_BIT];
			reqen_reg   <= reg_wdata_i[EPI_REQEN_BIT];
			pinen_reg   <= reg_wdata_i[EPI_PINEN_BIT];
			pol_reg     <= reg_wdata_i[EPI_POL_BIT];
			pulldis_reg <= reg_wdata_i[EPI_PULLDIS_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Event flag
	// ----------------------------------------------------------------

	// Edge always qualifies; in level mode the asserted level does too
	assign set_evt = det_bus.edge_evt ||
		(mode_reg && det_bus.level_act);

	// Acknowledge is void in level mode while the pin stays asserted
	assign ack_honoured = ack_wr &&
		!(mode_reg && det_bus.level_act);

	// A set in the same cycle as an acknowledge wins
	always_comb begin
		flag_next = flag_reg;
		if (ack_honoured) begin
			flag_next = 1'b0;
		end
		if (set_evt) begin
			flag_next = 1'b1;
		end
	end

	// Flag register
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			flag_reg <= EPI_CTRL_RESET[EPI_FLAG_BIT];
		end else begin
			flag_reg <= flag_next;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Acknowledge and bit 7 always read as zero
	always_comb begin
		ctrl_view                  = 8'h00;
		ctrl_view[EPI_MODE_BIT]    = mode_reg;
		ctrl_view[EPI_REQEN_BIT]   = reqen_reg;
		ctrl_view[EPI_FLAG_BIT]    = flag_reg;
		ctrl_view[EPI_PINEN_BIT]   = pinen_reg;
		ctrl_view[EPI_POL_BIT]     = pol_reg;
		ctrl_view[EPI_PULLDIS_BIT] = pulldis_reg;
	end

	// Data for one cycle after the strobe; zero otherwise or unmapped
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_reg <= 8'h00;
		end else if (ctrl_rd) begin
			rdata_reg <= ctrl_view;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	assign reg_rdata_o = rdata_reg;

	// ----------------------------------------------------------------
	// Pull device control
	// ----------------------------------------------------------------

	// Pull active only with pin function on and not disabled;
	// rising polarity turns it into a pulldown
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pull_en_reg <= 1'b0;
			pull_dn_reg <= 1'b0;
		end else begin
			pull_en_reg <= pinen_reg && !pulldis_reg;
			pull_dn_reg <= pinen_reg && pol_reg;
		end
	end

	assign pull_enable_o = pull_en_reg;
	assign pull_down_o   = pull_dn_reg;

	// ----------------------------------------------------------------
	// CPU request and vector
	// ----------------------------------------------------------------

	// Request follows the flag whenever requests are enabled
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= flag_next && (ctrl_wr ? reg_wdata_i[EPI_REQEN_BIT]
				: reqen_reg);
		end
	end

	assign cpu_irq_o     = irq_reg;
	assign vector_num_o  = EPI_VECTOR_NUM;
	assign vector_addr_o = EPI_VECTOR_ADDR;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	vector_fixed_a: assert property (
		vector_num_o == 5'h02 && vector_addr_o == 16'hfffa)
		else $error("vector number or address wrong");

	pin_off_quiet_a: assert property (
		!pinen_reg |-> !det_bus.edge_evt && !det_bus.level_act)
		else $error("event seen with pin function off");

	pull_ctrl_a: assert property (
		##1 pull_enable_o == $past(pinen_reg && !pulldis_reg))
		else $error("pull enable does not follow controls");

	pull_down_a: assert property (
		pinen_reg && pol_reg && !ctrl_wr |=> pull_down_o)
		else $error("pulldown not selected for rising polarity");

	falling_edge_a: assert property (
		pinen_reg && !pol_reg && !ctrl_wr ##1
		pinen_reg && !pol_reg && $fell(pin_level) && !ctrl_wr
		|=> flag_reg)
		else $error("falling edge did not set flag");

	rising_edge_a: assert property (
		pinen_reg && pol_reg && !ctrl_wr ##1
		pinen_reg && pol_reg && $rose(pin_level) && !ctrl_wr
		|=> flag_reg)
		else $error("rising edge did not set flag");

	edge_sets_a: assert property (
		det_bus.edge_evt |=> flag_reg)
		else $error("edge event lost");

	edge_only_a: assert property (
		!mode_reg && !det_bus.edge_evt && ack_wr |=> !flag_reg)
		else $error("level kept flag in edge mode");

	ack_clear_a: assert property (
		flag_reg && ack_wr && !set_evt |=> !flag_reg)
		else $error("acknowledge did not clear flag");

	no_ack_hold_a: assert property (
		!ack_wr && flag_reg |=> flag_reg)
		else $error("flag dropped without acknowledge");

	level_hold_a: assert property (
		mode_reg && det_bus.level_act |=> flag_reg)
		else $error("flag cleared while level asserted");

	read_zero_ack_a: assert property (
		ctrl_rd |=> reg_rdata_o[EPI_ACK_BIT] == 1'b0 &&
		reg_rdata_o[EPI_FLAG_BIT] == $past(flag_reg))
		else $error("read view of flag or acknowledge wrong");

	irq_follow_a: assert property (
		##1 cpu_irq_o == $past(flag_next && reqen_reg) || $past(ctrl_wr))
		else $error("request does not follow flag and enable");

	edge_to_irq_c: cover property (
		reqen_reg && !mode_reg && det_bus.edge_evt ##1 cpu_irq_o);
	level_ack_c: cover property (
		mode_reg && det_bus.level_act && ack_wr);
	ack_clear_c: cover property (flag_reg && ack_honoured ##1 !flag_reg);
	level_set_c: cover property (
		mode_reg && det_bus.level_act ##1 flag_reg);
	poll_only_c: cover property (!reqen_reg && flag_reg);

	// ----------------------------------------------------------------
	// Level run counter for the hold check
	// ----------------------------------------------------------------
	logic [2:0] level_run_reg;

	// Counts cycles of asserted level in level mode, saturating
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			level_run_reg <= 3'h0;
		end else if (mode_reg && det_bus.level_act) begin
			if (level_run_reg != 3'h7) begin
				level_run_reg <= level_run_reg + 3'h1;
			end
		end else begin
			level_run_reg <= 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// Flag, pull, request and read view checks
	// ----------------------------------------------------------------
	level_run_a: assert property (
		level_run_reg >= 3'h2 |-> flag_reg)
		else $error("flag low during a held asserted level");

	pull_off_a: assert property (
		!pinen_reg && !ctrl_wr |=> !pull_enable_o && !pull_down_o)
		else $error("pull device active with pin function off");

	pull_up_a: assert property (
		pinen_reg && !pol_reg && !ctrl_wr |=> !pull_down_o)
		else $error("pulldown chosen for falling polarity");

	pin_off_flag_a: assert property (
		!pinen_reg && !flag_reg && !ctrl_wr |=> !flag_reg)
		else $error("flag set with pin function off");

	no_req_poll_a: assert property (
		!reqen_reg && !ctrl_wr |=> !cpu_irq_o)
		else $error("request raised with requests disabled");

	req_follows_a: assert property (
		reqen_reg && !ctrl_wr |=> cpu_irq_o == flag_reg)
		else $error("request does not match flag");

	ack_zero_keep_a: assert property (
		ctrl_wr && !reg_wdata_i[EPI_ACK_BIT] && flag_reg |=> flag_reg)
		else $error("write of zero acknowledge cleared flag");

	rdata_zero_a: assert property (
		reg_rdata_o[EPI_ACK_BIT] == 1'b0 && reg_rdata_o[7] == 1'b0)
		else $error("acknowledge or spare bit read as one");

	idle_rdata_a: assert property (
		!ctrl_rd |=> reg_rdata_o == 8'h00)
		else $error("read data outside the read cycle");

endmodule : epi_top

// File: bench/epi_pin_src.sv
// Signal source model standing on the far side of the interrupt pin.
// Assumes the bench clock; the pin moves 37 ns after an edge, off grid.
`timescale 1ns/10ps
module epi_pin_src (
	input  wire logic mclk_i,
	input  wire logic drive_en_i,
	input  wire logic drive_val_i,
	input  wire logic pull_enable_i,
	input  wire logic pull_down_i,
	output logic      pin_o
);
	// Driven level, else the pull level, else a line that wanders
	initial pin_o = 1'b1;
	always @(posedge mclk_i) begin
		#37;
		if (drive_en_i)
			pin_o = drive_val_i;
		else if (pull_enable_i)
			pin_o = !pull_down_i;
		else
			pin_o = ~pin_o;
	end
endmodule : epi_pin_src

// File: bench/test_external_pin_interrupt.sv
// Self-checking bench for the external pin interrupt unit.
// Assumes epi_top with a plain register port and the pin source model.
`timescale 1ns/10ps
module test_external_pin_interrupt;
	import epi_pkg::*;
	logic                  mclk_i;
	logic                  reset_i;
	logic [EPI_ADDR_W-1:0] reg_addr_i;
	logic [7:0]            reg_wdata_i;
	logic                  reg_wr_i;
	logic                  reg_rd_i;
	logic [7:0]            reg_rdata_o;
	logic                  irq_pin_i;
	logic                  pull_enable_o;
	logic                  pull_down_o;
	logic                  cpu_irq_o;
	logic [4:0]            vector_num_o;
	logic [15:0]           vector_addr_o;
	logic                  pin_val;
	logic                  drive_en;
	logic                  rd_seen;
	logic [7:0]            exp_q[$];
	logic [7:0]            v;
	int                    bad_count;
	int                    n_compared;
	int                    seed;

	always #50 mclk_i = ~mclk_i;

	epi_top #(.SYNC_STAGES(2)) uut (
		.mclk_i        (mclk_i),
		.reset_i       (reset_i),
		.reg_addr_i    (reg_addr_i),
		.reg_wdata_i   (reg_wdata_i),
		.reg_wr_i      (reg_wr_i),
		.reg_rd_i      (reg_rd_i),
		.reg_rdata_o   (reg_rdata_o),
		.irq_pin_i     (irq_pin_i),
		.pull_enable_o (pull_enable_o),
		.pull_down_o   (pull_down_o),
		.cpu_irq_o     (cpu_irq_o),
		.vector_num_o  (vector_num_o),
		.vector_addr_o (vector_addr_o)
	);

	epi_pin_src src (
		.mclk_i        (mclk_i),
		.drive_en_i    (drive_en),
		.drive_val_i   (pin_val),
		.pull_enable_i (pull_enable_o),
		.pull_down_i   (pull_down_o),
		.pin_o         (irq_pin_i)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task end_of_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task do_reset;
		@(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		reset_i <= 1'b0;
		@(posedge mclk_i);
	endtask : do_reset

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// Read data are noted now and compared by the monitor
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		exp_q.push_back(e);
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
	endtask : rd

	task set_pin(input logic l);
		@(posedge mclk_i);
		pin_val <= l;
		repeat (5) @(posedge mclk_i);
	endtask : set_pin

	// Read data stand only in the cycle after the strobe
	always @(posedge mclk_i) begin
		rd_seen <= reg_rd_i;
		if (rd_seen)
			check("reg_rdata_o", reg_rdata_o, exp_q.pop_front());
	end

	// Watchdog against a hang
	initial begin
		#500000;
		bad_count++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk_i      = 1'b0;
		reset_i     = 1'b1;
		reg_addr_i  = 4'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i    = 1'b0;
		reg_rd_i    = 1'b0;
		pin_val     = 1'b1;
		drive_en    = 1'b1;
		rd_seen     = 1'b0;
		bad_count   = 0;
		n_compared  = 0;
		seed        = 32'he63ccef9;
		do_reset();
		check("vector_num_o", vector_num_o, 16'h0002);
		check("vector_addr_o", vector_addr_o, 16'hfffa);
		rd(4'h0, 8'h00);
		// Random pull settings with the pin held deasserted
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed)) & 8'h70;
			wr(4'h0, 8'h00);
			set_pin(!v[5]);
			wr(4'h0, v);
			repeat (3) @(posedge mclk_i);
			check("pull_enable_o", pull_enable_o, v[4] & !v[6]);
			check("pull_down_o", pull_down_o, v[4] & v[5]);
			rd(4'h0, v);
		end
		// Falling edge with request, then acknowledge
		wr(4'h0, 8'h00);
		set_pin(1'b1);
		wr(4'h0, 8'h12);
		set_pin(1'b0);
		check("cpu_irq_o", cpu_irq_o, 1'b1);
		rd(4'h0, 8'h1a);
		wr(4'h0, 8'h16);
		repeat (2) @(posedge mclk_i);
		check("cpu_irq_o", cpu_irq_o, 1'b0);
		rd(4'h0, 8'h12);
		// Rising edge
		wr(4'h0, 8'h32);
		set_pin(1'b1);
		rd(4'h0, 8'h3a);
		wr(4'h0, 8'h36);
		rd(4'h0, 8'h32);
		// Level mode: acknowledge refused while the pin stays low
		set_pin(1'b0);
		wr(4'h0, 8'h13);
		repeat (4) @(posedge mclk_i);
		rd(4'h0, 8'h1b);
		wr(4'h0, 8'h17);
		rd(4'h0, 8'h1b);
		set_pin(1'b1);
		wr(4'h0, 8'h17);
		rd(4'h0, 8'h13);
		// Released pin: pulldown gives no event, free line gives one
		wr(4'h0, 8'h32);
		@(posedge mclk_i);
		drive_en <= 1'b0;
		repeat (5) @(posedge mclk_i);
		check("irq_pin_i", irq_pin_i, 1'b0);
		rd(4'h0, 8'h32);
		wr(4'h0, 8'h72);
		repeat (5) @(posedge mclk_i);
		rd(4'h0, 8'h7a);
		@(posedge mclk_i);
		drive_en <= 1'b1;
		repeat (5) @(posedge mclk_i);
		wr(4'h0, 8'h36);
		rd(4'h0, 8'h32);
		// Pin function off: no event
		wr(4'h0, 8'h02);
		set_pin(1'b0);
		rd(4'h0, 8'h02);
		check("cpu_irq_o", cpu_irq_o, 1'b0);
		// Polling, then late request enable
		set_pin(1'b1);
		wr(4'h0, 8'h10);
		set_pin(1'b0);
		check("cpu_irq_o", cpu_irq_o, 1'b0);
		rd(4'h0, 8'h18);
		wr(4'h0, 8'h12);
		repeat (2) @(posedge mclk_i);
		check("cpu_irq_o", cpu_irq_o, 1'b1);
		// Unmapped places, then every writable bit
		wr(4'h3, 8'h00);
		rd(4'h5, 8'h00);
		rd(4'h0, 8'h1a);
		wr(4'h0, 8'hff);
		repeat (3) @(posedge mclk_i);
		check("pull_enable_o", pull_enable_o, 1'b0);
		rd(4'h0, 8'h73);
		// Reset in mid-run
		wr(4'h0, 8'h32);
		do_reset();
		rd(4'h0, 8'h00);
		check("cpu_irq_o", cpu_irq_o, 1'b0);
		repeat (3) @(posedge mclk_i);
		end_of_test();
	end
endmodule : test_external_pin_interrupt
